// ### iprc_chk.sv
// Purpose: Port checks on the priority register bank
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to the top module below
`timescale 1ns/1ps
`default_nettype none
module iprc_chk (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [2:0] out_compare_seven_prio,
	input wire logic [2:0] dma_chan_five_done_prio,
	input wire logic [2:0] codec_iface_event_prio,
	input wire logic [18:0] srcEnable
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// Taken address phases
	sequence wrTen; hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h00 ##1 1'b1; endsequence
	sequence rdLast; hsel && hready && htrans[1] && !hwrite && haddr[7:0] == 8'h14; endsequence
	chk_ready_high: assert property (hreadyout) else $error("ready low");
	chk_resp_okay: assert property (!hresp) else $error("resp not okay");
	chk_upper_zero: assert property (hrdata[31:16] == 16'h0) else $error("upper bits set");
	chk_gap_zero: assert property (!hrdata[15] && !hrdata[11] && !hrdata[7] && !hrdata[3])
		else $error("gap bit set");
	chk_write_lands: assert property (wrTen |=> out_compare_seven_prio == $past(hwdata[14:12]))
		else $error("write lost");
	chk_read_map: assert property (rdLast |=>
		hrdata[15:0] == {9'h0, $past(dma_chan_five_done_prio), 1'b0, $past(codec_iface_event_prio)})
		else $error("read map off");
	chk_zero_off: assert property (out_compare_seven_prio == 3'h0 |=> !srcEnable[0])
		else $error("zero field enabled");
	chk_code_on: assert property (codec_iface_event_prio != 3'h0 |=> srcEnable[18])
		else $error("field not enabled");
	chk_reset_four: assert property ($rose(resetn) |->
		out_compare_seven_prio == 3'h4 && srcEnable == 19'h7ffff) else $error("reset level off");
endmodule
bind iprc_top iprc_chk i_iprc_chk (.mclk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .hrdata, .hreadyout, .hresp, .out_compare_seven_prio, .dma_chan_five_done_prio,
	.codec_iface_event_prio, .srcEnable);
`default_nettype wire

// ### iprc_pkg.sv
// Purpose: Constants for the priority control register bank 10..15
// Assumes: AHB-Lite slave, 32-bit data, one aligned word per register
// Notes: Register offsets are local choices; fields are 3 bits wide
package iprc_pkg;
	// Register byte offsets
	localparam logic [7:0] IPRC_OFF_CTL10 = 8'h00;
	localparam logic [7:0] IPRC_OFF_CTL11 = 8'h04;
	localparam logic [7:0] IPRC_OFF_CTL12 = 8'h08;
	localparam logic [7:0] IPRC_OFF_CTL13 = 8'h0c;
	localparam logic [7:0] IPRC_OFF_CTL14 = 8'h10;
	localparam logic [7:0] IPRC_OFF_CTL15 = 8'h14;
	localparam int IPRC_NUM_REGS = 6;
	localparam int IPRC_ADDR_W = 8;
	// Field layout
	localparam int IPRC_FLD_W = 3;
	localparam int IPRC_POS_F3 = 12;
	localparam int IPRC_POS_F2 = 8;
	localparam int IPRC_POS_F1 = 4;
	localparam int IPRC_POS_F0 = 0;
	// Implemented-bit masks per register
	localparam logic [15:0] IPRC_MASK_CTL10 = 16'h7777;
	localparam logic [15:0] IPRC_MASK_CTL11 = 16'h7707;
	localparam logic [15:0] IPRC_MASK_CTL12 = 16'h7777;
	localparam logic [15:0] IPRC_MASK_CTL13 = 16'h7777;
	localparam logic [15:0] IPRC_MASK_CTL14 = 16'h7007;
	localparam logic [15:0] IPRC_MASK_CTL15 = 16'h0077;
	// Reset value of each field: level 4
	localparam logic [2:0] IPRC_FLD_RESET = 3'h4;
	// Field codes
	localparam logic [2:0] IPRC_LVL_OFF = 3'h0;
	localparam logic [2:0] IPRC_LVL_MAX = 3'h7;
	// AHB constants
	localparam logic [1:0] IPRC_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] IPRC_HTRANS_SEQ = 2'h3;
endpackage

// ### iprc_reg16.sv
// Purpose: One 16-bit priority register with masked implemented bits
// Assumes: Single clock, asynchronous active-low reset
// Notes: Unimplemented bits are held at zero in hardware
`timescale 1ns/1ps
`default_nettype none
module iprc_reg16 import iprc_pkg::*; #(
	parameter logic [15:0] MASK = 16'hffff
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic wrEn,
	input wire logic [15:0] wrData,
	output logic [15:0] value
);
	logic [15:0] val_ff;
	logic [15:0] nxt_val;

	// Each field resets to level 4: top bit set, lower two clear
	localparam logic [15:0] RESET_VAL = {4{1'b0, IPRC_FLD_RESET}} & MASK;

	// Next value: write lands only on implemented bits
	always_comb begin
		nxt_val = val_ff;
		if (wrEn) begin
			nxt_val = wrData & MASK;
		end
	end

	// State register
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			val_ff <= RESET_VAL;
		end else begin
			val_ff <= nxt_val;
		end
	end

	assign value = val_ff;
endmodule
`default_nettype wire

// ### iprc_resolver.sv
// Purpose: Far-side model that resolves the top requested level
// Assumes: Fields and enables arrive as steady levels
// Notes: Ties go to the lowest source index
`timescale 1ns/1ps
`default_nettype none
module iprc_resolver (
	input wire logic [18:0][2:0] fld,
	input wire logic [18:0] srcEnable,
	output logic [2:0] topLevel
);
	// Highest level among the enabled sources
	always_comb begin
		topLevel = 3'h0;
		for (int i = 0; i < 19; i++) begin
			if (srcEnable[i] && fld[i] > topLevel) begin
				topLevel = fld[i];
			end
		end
	end
endmodule
`default_nettype wire

// ### iprc_tb.sv
// Purpose: Self-checking bench for the priority register bank
// Assumes: Zero-wait slave at word offsets 0x00 to 0x14
// Notes: An array model gives every expected value except the zero read at the unmapped offset 0x18
`timescale 1ns/1ps
`default_nettype none
module iprc_tb;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] seed = 32'h20;
	wire hready;
	wire hresp;
	wire [31:0] hrdata;
	wire [18:0] srcEnable;
	wire [18:0][2:0] f;
	wire [2:0] topLevel;
	int errors = 0;
	int comparisons = 0;
	logic [15:0] mdl [6];
	logic [15:0] msk [6] = '{16'h7777, 16'h7707, 16'h7777, 16'h7777, 16'h7007, 16'h0077};
	always #50 mclk = ~mclk;
	iprc_top i_iprc_top (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .srcEnable(srcEnable),
		.out_compare_seven_prio(f[0]), .out_compare_six_prio(f[1]), .out_compare_five_prio(f[2]),
		.in_capture_six_prio(f[3]), .timer_six_prio(f[4]), .dma_chan_four_done_prio(f[5]),
		.out_compare_eight_prio(f[6]), .timer_eight_prio(f[7]), .i2c_port2_master_prio(f[8]),
		.i2c_port2_slave_prio(f[9]), .timer_seven_prio(f[10]), .can_port2_rx_prio(f[11]),
		.ext_irq_four_prio(f[12]), .ext_irq_three_prio(f[13]), .timer_nine_prio(f[14]),
		.codec_iface_error_prio(f[15]), .can_port2_event_prio(f[16]),
		.dma_chan_five_done_prio(f[17]), .codec_iface_event_prio(f[18]));
	iprc_resolver i_iprc_resolver (.fld(f), .srcEnable(srcEnable), .topLevel(topLevel));
	////////////////////////////////////////////////////////////////////////////////
	// Xorshift source, compare and verdict
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Bus cycles, reset and model
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		// Only the watchdog ends a wait for ready
		do @(posedge mclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input int r, input logic [31:0] d);
		logic [31:0] rd;
		xfer(1'b1, 8'(r * 4), d, rd);
		mdl[r] = d[15:0] & msk[r];
	endtask
	task automatic run_reset();
		resetn <= 1'b0;
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		for (int r = 0; r < 6; r++) mdl[r] = 16'h4444 & msk[r];
		@(posedge mclk);
	endtask
	task automatic check_all();
		logic [31:0] rd;
		logic [18:0] en;
		int lvl;
		int k;
		lvl = 0;
		k = 0;
		en = '0;
		for (int r = 0; r < 6; r++) begin
			xfer(1'b0, 8'(r * 4), 32'h0, rd);
			chk(rd, {16'h0, mdl[r]});
			for (int p = 12; p >= 0; p -= 4) begin
				if (msk[r][p]) begin
					chk(32'(f[k]), 32'(mdl[r][p +: 3]));
					en[k] = mdl[r][p +: 3] != 3'h0;
					if (en[k] && mdl[r][p +: 3] > lvl) lvl = mdl[r][p +: 3];
					k++;
				end
			end
		end
		chk(32'(srcEnable), 32'(en));
		chk(32'(topLevel), lvl);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [31:0] rd;
		run_reset();
		check_all();
		$display("test reset values done");
		for (int r = 0; r < 6; r++) wr(r, 32'hffffffff);
		xfer(1'b1, 8'h18, 32'h0, rd);
		xfer(1'b0, 8'h18, 32'h0, rd);
		chk(rd, 32'h0);
		check_all();
		$display("test ones and unmapped done");
		for (int r = 0; r < 6; r++) wr(r, 32'h0);
		check_all();
		for (int r = 0; r < 6; r++) wr(r, 32'h1111);
		check_all();
		$display("test codes done");
		for (int i = 0; i < 40; i++) begin
			wr(rnd() % 6, rnd());
			check_all();
		end
		$display("test random done");
		run_reset();
		check_all();
		$display("test second reset done");
		complete_run();
	end
	// Watchdog
	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		complete_run();
	end
endmodule
`default_nettype wire

// ### iprc_top.sv
// Purpose: AHB-Lite bank of interrupt priority control registers 10..15
// Assumes: 10 MHz mclk, single word transfers, OKAY response only
// Notes: Fields and their request-enable qualifiers go to priority resolution
//
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module iprc_top import iprc_pkg::*; (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic [2:0] out_compare_seven_prio,
	output logic [2:0] out_compare_six_prio,
	output logic [2:0] out_compare_five_prio,
	output logic [2:0] in_capture_six_prio,
	output logic [2:0] timer_six_prio,
	output logic [2:0] dma_chan_four_done_prio,
	output logic [2:0] out_compare_eight_prio,
	output logic [2:0] timer_eight_prio,
	output logic [2:0] i2c_port2_master_prio,
	output logic [2:0] i2c_port2_slave_prio,
	output logic [2:0] timer_seven_prio,
	output logic [2:0] can_port2_rx_prio,
	output logic [2:0] ext_irq_four_prio,
	output logic [2:0] ext_irq_three_prio,
	output logic [2:0] timer_nine_prio,
	output logic [2:0] codec_iface_error_prio,
	output logic [2:0] can_port2_event_prio,
	output logic [2:0] dma_chan_five_done_prio,
	output logic [2:0] codec_iface_event_prio,
	output logic [18:0] srcEnable
);

	////////////////////////////////////////////////////////////////////////////
	// Address phase capture
	logic wrPend_ff;
	logic [IPRC_ADDR_W-1:0] wrAddr_ff;
	logic nxt_wrPend;
	logic [IPRC_ADDR_W-1:0] nxt_wrAddr;
	logic [31:0] hrdata_ff;
	logic [31:0] nxt_hrdata;
	logic addrValid;
	logic [15:0] regVal [IPRC_NUM_REGS];
	logic [IPRC_NUM_REGS-1:0] regWr;
	logic [IPRC_NUM_REGS-1:0] addrHit;
	logic [15:0] rdWord;

	// A transfer is taken when selected, ready and NONSEQ or SEQ
	assign addrValid = hsel && hready && htrans[1];

	// One-hot register select from the low address bits; unmapped selects none
	always_comb begin
		addrHit = '0;
		case (haddr[IPRC_ADDR_W-1:0])
			IPRC_OFF_CTL10: addrHit[0] = 1'b1;
			IPRC_OFF_CTL11: addrHit[1] = 1'b1;
			IPRC_OFF_CTL12: addrHit[2] = 1'b1;
			IPRC_OFF_CTL13: addrHit[3] = 1'b1;
			IPRC_OFF_CTL14: addrHit[4] = 1'b1;
			IPRC_OFF_CTL15: addrHit[5] = 1'b1;
			default: addrHit = '0;
		endcase
	end

	// Word of the selected register, zero when nothing matches
	always_comb begin
		rdWord = 16'h0000;
		for (int i = 0; i < IPRC_NUM_REGS; i++) begin
			if (addrHit[i]) begin
				rdWord = regVal[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Write capture: address held over into the data phase
	always_comb begin
		nxt_wrPend = 1'b0;
		nxt_wrAddr = wrAddr_ff;
		if (addrValid) begin
			nxt_wrPend = hwrite;
			nxt_wrAddr = haddr[IPRC_ADDR_W-1:0];
		end
	end

	// Write capture state
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wrPend_ff <= 1'b0;
			wrAddr_ff <= '0;
		end else begin
			wrPend_ff <= nxt_wrPend;
			wrAddr_ff <= nxt_wrAddr;
		end
	end

	// Read data is taken in the address phase and stands through the data phase
	always_comb begin
		nxt_hrdata = hrdata_ff;
		if (addrValid && !hwrite) begin
			// Upper half and unimplemented bits read zero
			nxt_hrdata = {16'h0000, rdWord};
		end
	end

	// Read data register
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			hrdata_ff <= 32'h0000_0000;
		end else begin
			hrdata_ff <= nxt_hrdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Response: zero wait states, always OKAY
	logic hreadyout_ff;
	logic nxt_hreadyout;
	logic hresp_ff;
	logic nxt_hresp;

	// Next response values never change
	always_comb begin
		nxt_hreadyout = 1'b1;
		nxt_hresp = 1'b0;
	end

	// Ready is already high in reset, so the first transfer never waits
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			hreadyout_ff <= 1'b1;
			hresp_ff <= 1'b0;
		end else begin
			hreadyout_ff <= nxt_hreadyout;
			hresp_ff <= nxt_hresp;
		end
	end

	// Bus outputs straight from their flops
	assign hrdata = hrdata_ff;
	assign hreadyout = hreadyout_ff;
	assign hresp = hresp_ff;

	////////////////////////////////////////////////////////////////////////////
	// Register bank
	always_comb begin
		regWr = '0;
		case (wrAddr_ff)
			IPRC_OFF_CTL10: regWr[0] = wrPend_ff;
			IPRC_OFF_CTL11: regWr[1] = wrPend_ff;
			IPRC_OFF_CTL12: regWr[2] = wrPend_ff;
			IPRC_OFF_CTL13: regWr[3] = wrPend_ff;
			IPRC_OFF_CTL14: regWr[4] = wrPend_ff;
			IPRC_OFF_CTL15: regWr[5] = wrPend_ff;
			default: regWr = '0;
		endcase
	end

	// Register 10: bits 15, 11, 7 and 3 unimplemented
	iprc_reg16 #(.MASK(IPRC_MASK_CTL10)) u_reg10 (
		.mclk(mclk),
		.resetn(resetn),
		.wrEn(regWr[0]),
		.wrData(hwdata[15:0]),
		.value(regVal[0])
	);

	// Register 11: bits 15, 11 and 7 to 3 unimplemented
	iprc_reg16 #(.MASK(IPRC_MASK_CTL11)) u_reg11 (
		.mclk(mclk),
		.resetn(resetn),
		.wrEn(regWr[1]),
		.wrData(hwdata[15:0]),
		.value(regVal[1])
	);

	// Register 12: bits 15, 11, 7 and 3 unimplemented
	iprc_reg16 #(.MASK(IPRC_MASK_CTL12)) u_reg12 (
		.mclk(mclk),
		.resetn(resetn),
		.wrEn(regWr[2]),
		.wrData(hwdata[15:0]),
		.value(regVal[2])
	);

	// Register 13: bits 15, 11, 7 and 3 unimplemented
	iprc_reg16 #(.MASK(IPRC_MASK_CTL13)) u_reg13 (
		.mclk(mclk),
		.resetn(resetn),
		.wrEn(regWr[3]),
		.wrData(hwdata[15:0]),
		.value(regVal[3])
	);

	// Register 14: bits 15 and 11 to 3 unimplemented
	iprc_reg16 #(.MASK(IPRC_MASK_CTL14)) u_reg14 (
		.mclk(mclk),
		.resetn(resetn),
		.wrEn(regWr[4]),
		.wrData(hwdata[15:0]),
		.value(regVal[4])
	);

	// Register 15: bits 15 to 7 and 3 unimplemented
	iprc_reg16 #(.MASK(IPRC_MASK_CTL15)) u_reg15 (
		.mclk(mclk),
		.resetn(resetn),
		.wrEn(regWr[5]),
		.wrData(hwdata[15:0]),
		.value(regVal[5])
	);

	////////////////////////////////////////////////////////////////////////////
	// Field outputs straight from register flops
	// Register 10: output compare 7, 6, 5 and input capture 6
	assign out_compare_seven_prio = regVal[0][IPRC_POS_F3 +: IPRC_FLD_W];
	assign out_compare_six_prio = regVal[0][IPRC_POS_F2 +: IPRC_FLD_W];
	assign out_compare_five_prio = regVal[0][IPRC_POS_F1 +: IPRC_FLD_W];
	assign in_capture_six_prio = regVal[0][IPRC_POS_F0 +: IPRC_FLD_W];

	// Register 11: timer 6, DMA channel 4 done, output compare 8
	assign timer_six_prio = regVal[1][IPRC_POS_F3 +: IPRC_FLD_W];
	assign dma_chan_four_done_prio = regVal[1][IPRC_POS_F2 +: IPRC_FLD_W];
	assign out_compare_eight_prio = regVal[1][IPRC_POS_F0 +: IPRC_FLD_W];

	// Register 12: timer 8, second I2C master and slave, timer 7
	assign timer_eight_prio = regVal[2][IPRC_POS_F3 +: IPRC_FLD_W];
	assign i2c_port2_master_prio = regVal[2][IPRC_POS_F2 +: IPRC_FLD_W];
	assign i2c_port2_slave_prio = regVal[2][IPRC_POS_F1 +: IPRC_FLD_W];
	assign timer_seven_prio = regVal[2][IPRC_POS_F0 +: IPRC_FLD_W];

	// Register 13: second CAN receive, external 4 and 3, timer 9
	assign can_port2_rx_prio = regVal[3][IPRC_POS_F3 +: IPRC_FLD_W];
	assign ext_irq_four_prio = regVal[3][IPRC_POS_F2 +: IPRC_FLD_W];
	assign ext_irq_three_prio = regVal[3][IPRC_POS_F1 +: IPRC_FLD_W];
	assign timer_nine_prio = regVal[3][IPRC_POS_F0 +: IPRC_FLD_W];

	// Register 14: codec interface error, second CAN events
	assign codec_iface_error_prio = regVal[4][IPRC_POS_F3 +: IPRC_FLD_W];
	assign can_port2_event_prio = regVal[4][IPRC_POS_F0 +: IPRC_FLD_W];

	// Register 15: DMA channel 5 done, codec interface events
	assign dma_chan_five_done_prio = regVal[5][IPRC_POS_F1 +: IPRC_FLD_W];
	assign codec_iface_event_prio = regVal[5][IPRC_POS_F0 +: IPRC_FLD_W];

	////////////////////////////////////////////////////////////////////////////
	// Source enable flops: a zero code blocks any request, codes 1..7 pass
	logic [18:0] srcEnable_ff;
	logic [18:0] nxt_srcEnable;

	always_comb begin
		// Register 10 sources
		nxt_srcEnable[0] = out_compare_seven_prio != IPRC_LVL_OFF;
		nxt_srcEnable[1] = out_compare_six_prio != IPRC_LVL_OFF;
		nxt_srcEnable[2] = out_compare_five_prio != IPRC_LVL_OFF;
		nxt_srcEnable[3] = in_capture_six_prio != IPRC_LVL_OFF;
		// Register 11 sources
		nxt_srcEnable[4] = timer_six_prio != IPRC_LVL_OFF;
		nxt_srcEnable[5] = dma_chan_four_done_prio != IPRC_LVL_OFF;
		nxt_srcEnable[6] = out_compare_eight_prio != IPRC_LVL_OFF;
		// Register 12 sources
		nxt_srcEnable[7] = timer_eight_prio != IPRC_LVL_OFF;
		nxt_srcEnable[8] = i2c_port2_master_prio != IPRC_LVL_OFF;
		nxt_srcEnable[9] = i2c_port2_slave_prio != IPRC_LVL_OFF;
		nxt_srcEnable[10] = timer_seven_prio != IPRC_LVL_OFF;
		// Register 13 sources
		nxt_srcEnable[11] = can_port2_rx_prio != IPRC_LVL_OFF;
		nxt_srcEnable[12] = ext_irq_four_prio != IPRC_LVL_OFF;
		nxt_srcEnable[13] = ext_irq_three_prio != IPRC_LVL_OFF;
		nxt_srcEnable[14] = timer_nine_prio != IPRC_LVL_OFF;
		// Register 14 sources
		nxt_srcEnable[15] = codec_iface_error_prio != IPRC_LVL_OFF;
		nxt_srcEnable[16] = can_port2_event_prio != IPRC_LVL_OFF;
		// Register 15 sources
		nxt_srcEnable[17] = dma_chan_five_done_prio != IPRC_LVL_OFF;
		nxt_srcEnable[18] = codec_iface_event_prio != IPRC_LVL_OFF;
	end

	// Enable register, all sources enabled at reset level four
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			srcEnable_ff <= {19{1'b1}};
		end else begin
			srcEnable_ff <= nxt_srcEnable;
		end
	end

	assign srcEnable = srcEnable_ff;
endmodule
`default_nettype wire
